//--- verilog/nor_erase_sequencer.sv
// Erase sequencer of a serial NOR flash: gates, times and reports erases.
// Assumes a command decoder on mclk_in presents each decoded command with
// cmd_valid_in while chip select is still low; chip select is a raw pin.
`timescale 1ns/1ns
module nor_erase_sequencer #(
  parameter int ADDR_W    = 25,
  parameter int T4K_CYC   = nes_pkg::T4K_CYC,
  parameter int T256K_CYC = nes_pkg::T256K_CYC,
  parameter int TCHIP_CYC = nes_pkg::TCHIP_CYC,
  parameter int TPPB_CYC  = nes_pkg::TPPB_CYC,
  parameter int TEES_CYC  = nes_pkg::TEES_CYC,
  parameter int TSEC_CYC  = nes_pkg::TSEC_CYC,
  parameter int NUM_SECT  = 1 << (ADDR_W - nes_pkg::SECT_SH),
  parameter int SECT_W    = ADDR_W - nes_pkg::SECT_SH
) (
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  input  wire logic                ce_in,
  input  wire logic                cs_n_in,
  input  wire logic                cmd_valid_in,
  input  wire logic [3:0]          cmd_code_in,
  input  wire logic [31:0]         cmd_addr_in,
  input  wire logic                clear_fail_in,
  input  wire logic [7:0]          config_three_volatile_in,
  input  wire logic [1:0]          hybrid_sel_in,
  input  wire logic                blank_check_enable_in,
  input  wire logic                sector_blank_in,
  input  wire logic [2:0]          block_protect_in,
  input  wire logic [NUM_SECT-1:0] dynamic_protect_bits_in,
  input  wire logic [3:0]          sector_protect_options_in,
  input  wire logic                persist_prot_lock_bit_in,
  input  wire logic                ppb_program_in,
  input  wire logic [SECT_W-1:0]   ppb_sector_in,
  output logic [7:0]               status_one_volatile_out,
  output logic [7:0]               status_two_volatile_out,
  output logic [23:0]              erase_count_reg_out,
  output logic                     erase_start_out,
  output logic [31:0]              erase_addr_out,
  output logic [31:0]              erase_len_out,
  output logic [NUM_SECT-1:0]      erase_keep_out,
  output logic [7:0]               erase_fill_out
);
  typedef enum {S_IDLE, S_ARM, S_RUN} nes_state_e;

  nes_state_e                  state_r;
  nes_pkg::nes_act_e           act;
  logic                        cs_m_r, cs_s_r, cs_d_r;
  logic                        busy_r, wel_r, fail_r, ers_ok_r;
  logic [3:0]                  code_r;
  logic [31:0]                 addr_r;
  logic [NUM_SECT-1:0]         done_r, ppb_r, par_r;
  logic [nes_pkg::CNT_W-1:0]   cnt_r [NUM_SECT];
  logic [nes_pkg::TMR_W-1:0]   ld_cnt, ld_r, run_cnt;
  logic [31:0]                 e_addr, e_len, off, base, lo, hi;
  logic [SECT_W-1:0]           sect;
  logic                        cs_rise, decide, go, fin, tmr_done;
  logic                        uniform, is_small, prot, bp_prot, locked;
  logic                        is_erase, corrupt, done_sel;

  // Chip select is a pin, so it passes two flops before any edge detect.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else if (ce_in) begin
      cs_m_r <= cs_n_in;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
    end
  end

  assign cs_rise  = cs_s_r && !cs_d_r;
  assign decide   = ce_in && (state_r == S_ARM) && cs_rise;
  assign go       = decide && (act == nes_pkg::ACT_GO);
  assign fin      = ce_in && (state_r == S_RUN) && tmr_done;
  assign sect     = addr_r[ADDR_W-1:nes_pkg::SECT_SH];
  assign off      = 32'(addr_r[nes_pkg::SECT_SH-1:0]);
  assign base     = 32'(sect) << nes_pkg::SECT_SH;
  assign uniform  = config_three_volatile_in[nes_pkg::CR3_UNIF];
  assign done_sel = done_r[sect];
  assign corrupt  = (^cnt_r[sect]) != par_r[sect];
  assign is_erase = (code_r == nes_pkg::CMD_SMALL) ||
                    (code_r == nes_pkg::CMD_LARGE) ||
                    (code_r == nes_pkg::CMD_CHIP) ||
                    (code_r == nes_pkg::CMD_PPB);
  assign locked   = sector_protect_options_in[nes_pkg::SECTOR_PROTECT_OPTIONS_PPBLK] ||
                    sector_protect_options_in[nes_pkg::SECTOR_PROTECT_OPTIONS_PERM] ||
                    persist_prot_lock_bit_in;

  // Block protection guards a top slice of sectors that grows with the level.
  always_comb begin
    logic [SECT_W:0] from_top;
    from_top = (SECT_W+1)'(NUM_SECT - 1) - (SECT_W+1)'(sect);
    bp_prot  = (block_protect_in != 3'h0) &&
               (from_top < ((SECT_W+1)'(1) << (block_protect_in - 3'h1)));
  end
  assign prot = bp_prot || dynamic_protect_bits_in[sect] || !ppb_r[sect];

  // Overlay sizes of the small-sector region at each end of the array.
  always_comb begin
    lo = '0;
    hi = '0;
    if (!uniform) begin
      case (hybrid_sel_in)
        nes_pkg::HYB_BOT: lo = nes_pkg::SZ_128K;
        nes_pkg::HYB_TOP: hi = nes_pkg::SZ_128K;
        default: begin
          lo = nes_pkg::SZ_64K;
          hi = nes_pkg::SZ_64K;
        end
      endcase
    end
    is_small = ((sect == '0) && (off < lo)) ||
               ((sect == SECT_W'(NUM_SECT - 1)) &&
                (off >= nes_pkg::SZ_256K - hi));
  end

  // Decision taken at the chip-select rise that closes the command.
  always_comb begin
    act    = nes_pkg::ACT_IGN;
    ld_cnt = '0;
    e_addr = '0;
    e_len  = '0;
    case (code_r)
      nes_pkg::CMD_SMALL: begin
        e_addr = {addr_r[31:nes_pkg::SMALL_SH], 12'h000};
        e_len  = 32'h0000_1000;
        ld_cnt = nes_pkg::TMR_W'(T4K_CYC);
        if (uniform || !wel_r) act = nes_pkg::ACT_IGN;
        else if (!is_small) act = nes_pkg::ACT_ABORT;
        else if (prot) act = nes_pkg::ACT_FAIL;
        else if (blank_check_enable_in && sector_blank_in) begin
          act = nes_pkg::ACT_ABORT;
        end else act = nes_pkg::ACT_GO;
      end
      nes_pkg::CMD_LARGE: begin
        // Visible remainder only; uniform leaves lo and hi at zero.
        e_addr = base + ((sect == '0) ? lo : '0);
        e_len  = nes_pkg::SZ_256K - ((sect == '0) ? lo : '0) -
                 ((sect == SECT_W'(NUM_SECT - 1)) ? hi : '0);
        ld_cnt = nes_pkg::TMR_W'(T256K_CYC);
        if (!wel_r) act = nes_pkg::ACT_IGN;
        else if (prot) act = nes_pkg::ACT_FAIL;
        else if (blank_check_enable_in && sector_blank_in) begin
          act = nes_pkg::ACT_ABORT;
        end else act = nes_pkg::ACT_GO;
      end
      nes_pkg::CMD_CHIP: begin
        e_len  = nes_pkg::SZ_256K * 32'(NUM_SECT);
        ld_cnt = nes_pkg::TMR_W'(TCHIP_CYC);
        if (!wel_r) act = nes_pkg::ACT_IGN;
        else if (block_protect_in != 3'h0) act = nes_pkg::ACT_ABORT;
        else act = nes_pkg::ACT_GO;
      end
      nes_pkg::CMD_PPB: begin
        ld_cnt = nes_pkg::TMR_W'(TPPB_CYC);
        if (!wel_r) act = nes_pkg::ACT_IGN;
        else if (locked) act = nes_pkg::ACT_FAIL;
        else act = nes_pkg::ACT_GO;
      end
      nes_pkg::CMD_EVAL: begin
        ld_cnt = nes_pkg::TMR_W'(TEES_CYC);
        act    = nes_pkg::ACT_GO;
      end
      nes_pkg::CMD_COUNT: begin
        ld_cnt = nes_pkg::TMR_W'(TSEC_CYC);
        act    = nes_pkg::ACT_GO;
      end
      default: act = nes_pkg::ACT_IGN;
    endcase
  end

  nes_timer #(
    .W        (nes_pkg::TMR_W)
  ) u_timer (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .load_in  (go),
    .count_in (ld_cnt),
    .done_out (tmr_done)
  );

  // Commands are taken only while idle; anything during an erase is dropped.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= S_IDLE;
      busy_r  <= 1'b0;
      code_r  <= 4'h0;
      addr_r  <= 32'h0000_0000;
    end else if (ce_in) begin
      case (state_r)
        S_IDLE: begin
          if (cmd_valid_in && (cmd_code_in != nes_pkg::CMD_WREN) &&
              (cmd_code_in != 4'h0)) begin
            code_r  <= cmd_code_in;
            addr_r  <= cmd_addr_in;
            state_r <= S_ARM;
          end
        end
        S_ARM: begin
          if (go) begin
            state_r <= S_RUN;
            busy_r  <= 1'b1;
          end else if (cs_rise) begin
            state_r <= S_IDLE;
          end
        end
        S_RUN: begin
          if (fin) begin
            state_r <= S_IDLE;
            busy_r  <= 1'b0;
          end
        end
        default: begin
          state_r <= S_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // Write-enable latch: set by its command, cleared when an erase ends.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wel_r <= 1'b0;
    end else if (ce_in) begin
      if (state_r == S_IDLE && cmd_valid_in &&
          cmd_code_in == nes_pkg::CMD_WREN) begin
        wel_r <= 1'b1;
      end else if ((fin || (decide && act != nes_pkg::ACT_IGN &&
                    act != nes_pkg::ACT_GO)) && is_erase) begin
        wel_r <= 1'b0;
      end
    end
  end

  // Failure flag; a refusal in the same cycle as a clear keeps the flag.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fail_r <= 1'b0;
    end else if (ce_in) begin
      if (decide && act == nes_pkg::ACT_FAIL) fail_r <= 1'b1;
      else if (clear_fail_in) fail_r <= 1'b0;
    end
  end

  // Array request; the array fills the range with the erased pattern.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      erase_start_out <= 1'b0;
      erase_addr_out  <= 32'h0000_0000;
      erase_len_out   <= 32'h0000_0000;
      erase_keep_out  <= '0;
      erase_fill_out  <= nes_pkg::ERASED;
    end else if (ce_in) begin
      erase_start_out <= go && (code_r == nes_pkg::CMD_SMALL ||
                         code_r == nes_pkg::CMD_LARGE ||
                         code_r == nes_pkg::CMD_CHIP);
      erase_fill_out  <= nes_pkg::ERASED;
      if (go) begin
        erase_addr_out <= e_addr;
        erase_len_out  <= e_len;
        erase_keep_out <= (code_r == nes_pkg::CMD_CHIP) ?
                          (dynamic_protect_bits_in | ~ppb_r) : '0;
      end
    end
  end

  // Per-sector completion marks, erase counts and persistent protection.
  // The completion mark drops at start, so a lost erase stays visible.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      done_r <= '1;
      ppb_r  <= '1;
      par_r  <= '0;
      for (int s = 0; s < NUM_SECT; s++) cnt_r[s] <= '0;
    end else if (ce_in) begin
      if (ppb_program_in && state_r == S_IDLE) ppb_r[ppb_sector_in] <= 1'b0;
      if (go && (code_r == nes_pkg::CMD_SMALL ||
                 code_r == nes_pkg::CMD_LARGE)) done_r[sect] <= 1'b0;
      if (go && code_r == nes_pkg::CMD_CHIP) begin
        done_r <= done_r & (dynamic_protect_bits_in | ~ppb_r);
      end
      if (fin) begin
        case (code_r)
          nes_pkg::CMD_SMALL, nes_pkg::CMD_LARGE: begin
            done_r[sect] <= 1'b1;
            cnt_r[sect]  <= cnt_r[sect] + nes_pkg::CNT_W'(1);
            par_r[sect]  <= ^(cnt_r[sect] + nes_pkg::CNT_W'(1));
          end
          nes_pkg::CMD_CHIP: begin
            for (int s = 0; s < NUM_SECT; s++) begin
              if (!erase_keep_out[s]) begin
                done_r[s] <= 1'b1;
                cnt_r[s]  <= cnt_r[s] + nes_pkg::CNT_W'(1);
                par_r[s]  <= ^(cnt_r[s] + nes_pkg::CNT_W'(1));
              end
            end
          end
          nes_pkg::CMD_PPB: ppb_r <= '1;
          nes_pkg::CMD_COUNT: begin
            if (corrupt) begin
              cnt_r[sect] <= '0;
              par_r[sect] <= 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Evaluation result and count register update only at completion.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ers_ok_r            <= 1'b0;
      erase_count_reg_out <= 24'h00_0000;
    end else if (ce_in && fin) begin
      if (code_r == nes_pkg::CMD_EVAL) ers_ok_r <= done_sel;
      if (code_r == nes_pkg::CMD_COUNT) begin
        erase_count_reg_out <= corrupt ? 24'h80_0000 :
                               {1'b0, cnt_r[sect]};
      end
    end
  end

  always_comb begin
    status_one_volatile_out = 8'h00;
    status_one_volatile_out[nes_pkg::ST1_BUSY] = busy_r;
    status_one_volatile_out[nes_pkg::ST1_WEL]  = wel_r;
    status_one_volatile_out[nes_pkg::ST1_FAIL] = fail_r;
    status_two_volatile_out = 8'h00;
    status_two_volatile_out[nes_pkg::ST2_ERS_OK] = ers_ok_r;
  end

  // Helper: cycles spent running, compared against the loaded duration.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      run_cnt <= '0;
      ld_r    <= '0;
    end else if (ce_in) begin
      if (go) begin
        run_cnt <= '0;
        ld_r    <= ld_cnt;
      end else if (state_r == S_RUN) begin
        run_cnt <= run_cnt + nes_pkg::TMR_W'(1);
      end
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  AST_WEL_GATE: assert property (go && is_erase |-> wel_r)
    else $error("erase started without write enable");
  AST_WEL_CLR: assert property (fin && is_erase |=> !wel_r)
    else $error("write enable not cleared after erase");
  AST_BUSY_RUN: assert property (go |=>
    status_one_volatile_out[nes_pkg::ST1_BUSY] [*5])
    else $error("busy dropped during operation");
  AST_FAIL_PROT: assert property (decide && act == nes_pkg::ACT_FAIL
    |=> status_one_volatile_out[nes_pkg::ST1_FAIL])
    else $error("refused erase did not set failure");
  AST_START_CS: assert property ($rose(busy_r) |-> $past(cs_rise))
    else $error("operation started without chip select rise");
  AST_UNIF_IGN: assert property (decide && code_r == nes_pkg::CMD_SMALL &&
    uniform |=> state_r == S_IDLE && wel_r == $past(wel_r))
    else $error("small erase not ignored in uniform mode");
  AST_SMALL_OUT: assert property (decide && code_r == nes_pkg::CMD_SMALL &&
    !uniform && wel_r && !is_small |=> !busy_r && !$rose(fail_r))
    else $error("small erase outside region misbehaved");
  AST_CHIP_BP: assert property (decide && code_r == nes_pkg::CMD_CHIP &&
    block_protect_in != 3'h0 |=> !busy_r && !$rose(fail_r))
    else $error("full erase ran under block protection");
  AST_PPB_LOCK: assert property (decide && code_r == nes_pkg::CMD_PPB &&
    locked |=> state_r == S_IDLE)
    else $error("protection-bit erase ran while locked");
  AST_EVAL_VAL: assert property (fin && code_r == nes_pkg::CMD_EVAL
    |=> status_two_volatile_out[nes_pkg::ST2_ERS_OK] ==
    $past(done_sel))
    else $error("evaluate result mismatch");
  AST_EVAL_TIME: assert property (fin && code_r == nes_pkg::CMD_EVAL
    |-> run_cnt == ld_r)
    else $error("evaluate duration wrong");
  AST_CNT_TIME: assert property (fin && code_r == nes_pkg::CMD_COUNT
    |-> run_cnt == ld_r ##1 !busy_r)
    else $error("count query duration wrong");

  CV_LARGE: cover property (fin && code_r == nes_pkg::CMD_LARGE);
  CV_CHIP: cover property (fin && code_r == nes_pkg::CMD_CHIP);
  CV_COUNT: cover property (fin && code_r == nes_pkg::CMD_COUNT);
  CV_FAIL: cover property (decide && act == nes_pkg::ACT_FAIL);
endmodule : nor_erase_sequencer

//--- verilog/nes_pkg.sv
// Shared constants for the erase sequencer: status bit positions, sector
// geometry, command codes and self-timed durations.
// Assumes a single 125 MHz clock domain for every user of the package.
package nes_pkg;
  localparam int CLK_NS = 8;
  // Self-timed durations in microseconds; cycle counts round up.
  localparam int T4K_US   = 30;
  localparam int T256K_US = 500;
  localparam int TCHIP_US = 5000;
  localparam int TPPB_US  = 100;
  localparam int TEES_US  = 20;
  localparam int TSEC_US  = 20;
  localparam int T4K_CYC   = (T4K_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int T256K_CYC = (T256K_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TCHIP_CYC = (TCHIP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TPPB_CYC  = (TPPB_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TEES_CYC  = (TEES_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TSEC_CYC  = (TSEC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W     = 32;

  localparam int ST1_BUSY   = 0;
  localparam int ST1_WEL    = 1;
  localparam int ST1_FAIL   = 5;
  localparam int ST2_ERS_OK = 2;
  localparam int CR3_UNIF   = 3;
  localparam int SECTOR_PROTECT_OPTIONS_PPBLK = 3;
  localparam int SECTOR_PROTECT_OPTIONS_PERM  = 0;
  localparam int CNT_W      = 23;
  localparam int SEC_CORRUPT = 23;

  localparam int SECT_SH = 18;
  localparam int SMALL_SH = 12;
  localparam logic [31:0] SZ_64K  = 32'h0001_0000;
  localparam logic [31:0] SZ_128K = 32'h0002_0000;
  localparam logic [31:0] SZ_256K = 32'h0004_0000;
  localparam logic [7:0]  ERASED  = 8'hFF;

  localparam logic [1:0] HYB_BOT = 2'h0;
  localparam logic [1:0] HYB_TOP = 2'h1;

  localparam logic [3:0] CMD_WREN  = 4'h1;
  localparam logic [3:0] CMD_SMALL = 4'h2;
  localparam logic [3:0] CMD_LARGE = 4'h3;
  localparam logic [3:0] CMD_CHIP  = 4'h4;
  localparam logic [3:0] CMD_PPB   = 4'h5;
  localparam logic [3:0] CMD_EVAL  = 4'h6;
  localparam logic [3:0] CMD_COUNT = 4'h7;

  typedef enum logic [1:0] {ACT_IGN, ACT_ABORT, ACT_FAIL, ACT_GO} nes_act_e;
endpackage : nes_pkg

//--- verilog/nes_timer.sv
// Down-counter that times one self-timed operation.
// Assumes load and count come from logic on the same clock.
`timescale 1ns/1ns
module nes_timer #(
  parameter int W = 32
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);
  logic [W-1:0] cnt_r;

  // Done pulses on the edge where the count reaches zero.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r    <= '0;
      done_out <= 1'b0;
    end else if (ce_in) begin
      if (load_in) begin
        cnt_r    <= count_in;
        done_out <= 1'b0;
      end else if (cnt_r != '0) begin
        cnt_r    <= cnt_r - W'(1);
        done_out <= (cnt_r == W'(1));
      end else begin
        done_out <= 1'b0;
      end
    end
  end
endmodule : nes_timer

//--- testbench/nes_host_model.sv
// Host model: hands the sequencer decoded commands framed by chip select.
// Assumes the bench calls send only once busy has dropped.
`timescale 1ns/1ns
module nes_host_model (
  input  wire logic  mclk_in,
  output logic       cs_n_out,
  output logic       cmd_valid_out,
  output logic [3:0] cmd_code_out,
  output logic [31:0] cmd_addr_out
);
  initial begin
    cs_n_out = 1'b1;
    cmd_valid_out = 1'b0;
    cmd_code_out = 4'h0;
    cmd_addr_out = 32'h0;
  end
  // Code and address are inverted once released so stale values never help.
  task automatic send(input logic [3:0] c, input logic [31:0] a);
    @(negedge mclk_in) cs_n_out = 1'b0;
    @(negedge mclk_in) cmd_valid_out = 1'b1;
    cmd_code_out = c;
    cmd_addr_out = a;
    @(negedge mclk_in) cmd_valid_out = 1'b0;
    cmd_code_out = ~c;
    cmd_addr_out = ~a;
    @(negedge mclk_in) cs_n_out = 1'b1;
  endtask : send
endmodule : nes_host_model

//--- testbench/nor_erase_sequencer_test.sv
// Bench for the erase sequencer: command sequences with expected status.
// Assumes the host model and all design inputs change on falling edges.
`timescale 1ns/1ns
module nor_erase_sequencer_test;
  localparam int TC = 8;
  logic mclk_in = 0, rst_in = 1, clr = 0, ben = 0, blank = 0, lock = 0;
  logic ce = 1, pprog = 0;
  logic [3:0] spo = 4'h0;
  logic [6:0] psec = 7'h00;
  logic [7:0] cfg = 8'h08, so, s2, fill;
  logic [1:0] hyb = 2'h0;
  logic [2:0] bp = 3'h0;
  logic [127:0] dynamic_protect_bits = '0, keep;
  logic [23:0] cnt;
  logic [31:0] ea, el, ca;
  logic cs_n, cv, st;
  logic [3:0] cc;
  int miscompares = 0, tests_run = 0, starts = 0, bl, cyc = 0;
  always #4 mclk_in = ~mclk_in;
  nes_host_model nes_host_model_i (.mclk_in(mclk_in), .cs_n_out(cs_n),
    .cmd_valid_out(cv), .cmd_code_out(cc), .cmd_addr_out(ca));
  nor_erase_sequencer #(.T4K_CYC(TC), .T256K_CYC(TC), .TCHIP_CYC(TC),
    .TPPB_CYC(TC), .TEES_CYC(TC), .TSEC_CYC(TC)) nor_erase_sequencer_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce), .cs_n_in(cs_n),
    .cmd_valid_in(cv), .cmd_code_in(cc), .cmd_addr_in(ca),
    .clear_fail_in(clr), .config_three_volatile_in(cfg),
    .hybrid_sel_in(hyb), .blank_check_enable_in(ben),
    .sector_blank_in(blank), .block_protect_in(bp),
    .dynamic_protect_bits_in(dynamic_protect_bits), .sector_protect_options_in(spo),
    .persist_prot_lock_bit_in(lock), .ppb_program_in(pprog),
    .ppb_sector_in(psec), .status_one_volatile_out(so),
    .status_two_volatile_out(s2), .erase_count_reg_out(cnt),
    .erase_start_out(st), .erase_addr_out(ea), .erase_len_out(el),
    .erase_keep_out(keep), .erase_fill_out(fill));
  always @(posedge mclk_in) begin
    if (st === 1'b1) starts++;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic check(input string n, input logic [127:0] s, e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask : check
  // Busy must equal go within six cycles of chip select; its length lands in bl.
  task automatic op(input logic [3:0] c, input logic [31:0] a, input bit go);
    int n;
    nes_host_model_i.send(c, a);
    n = 0;
    while (so[0] !== 1'b1 && n < 6) begin
      @(negedge mclk_in) n++;
    end
    check("busy", so[0], go);
    bl = 0;
    while (so[0] !== 1'b0 && bl < 60) begin
      @(negedge mclk_in) bl++;
    end
    repeat (2) @(negedge mclk_in);
  endtask : op
  task automatic wren();
    nes_host_model_i.send(nes_pkg::CMD_WREN, 32'h0);
  endtask : wren
  task automatic clear_fail();
    @(negedge mclk_in) clr = 1;
    @(negedge mclk_in) clr = 0;
  endtask : clear_fail
  task automatic note(input string n);
    $display("test %s done", n);
  endtask : note
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (12) @(negedge mclk_in);
    rst_in = 0;
    ce = 0;
    wren();
    ce = 1;
    check("frozen", so[1], 0);
    wren();
    op(nes_pkg::CMD_LARGE, 32'h0004_0000, 1);
    check("starts", starts, 1);
    check("len", el, nes_pkg::SZ_256K);
    check("fill", fill, nes_pkg::ERASED);
    check("busy_len", bl, TC + 1);
    check("wel", so[1], 0);
    op(nes_pkg::CMD_LARGE, 32'h0004_0000, 0);
    check("starts", starts, 1);
    wren();
    op(nes_pkg::CMD_SMALL, 32'h0, 0);
    check("wel", so[1], 1);
    note("uniform");
    cfg = 8'h00;
    op(nes_pkg::CMD_SMALL, 32'h0100_0000, 0);
    check("st1", so, 8'h00);
    wren();
    op(nes_pkg::CMD_LARGE, 32'h0, 1);
    check("addr", ea, nes_pkg::SZ_128K);
    check("len", el, nes_pkg::SZ_128K);
    note("hybrid");
    bp = 3'h1;
    wren();
    op(nes_pkg::CMD_LARGE, 32'h01FC_0000, 0);
    check("st1", so, 8'h20);
    clear_fail();
    check("fail", so[5], 0);
    wren();
    op(nes_pkg::CMD_CHIP, 32'h0, 0);
    check("st1", so, 8'h00);
    bp = 3'h0;
    dynamic_protect_bits[5] = 1'b1;
    wren();
    op(nes_pkg::CMD_CHIP, 32'h0, 1);
    check("keep", keep, 128'h20);
    check("st1", so, 8'h00);
    note("protect");
    ben = 1;
    blank = 1;
    wren();
    op(nes_pkg::CMD_LARGE, 32'h0008_0000, 0);
    check("st1", so, 8'h00);
    ben = 0;
    lock = 1;
    wren();
    op(nes_pkg::CMD_PPB, 32'h0, 0);
    check("fail", so[5], 1);
    lock = 0;
    spo = 4'h8;
    clear_fail();
    wren();
    op(nes_pkg::CMD_PPB, 32'h0, 0);
    check("st1", so, 8'h20);
    spo = 4'h0;
    clear_fail();
    @(negedge mclk_in) pprog = 1;
    psec = 7'h03;
    @(negedge mclk_in) pprog = 0;
    wren();
    op(nes_pkg::CMD_LARGE, 32'h000C_0000, 0);
    check("st1", so, 8'h20);
    clear_fail();
    wren();
    op(nes_pkg::CMD_PPB, 32'h0, 1);
    check("st1", so, 8'h00);
    wren();
    op(nes_pkg::CMD_LARGE, 32'h000C_0000, 1);
    check("addr", ea, 32'h000C_0000);
    note("blank_ppb");
    op(nes_pkg::CMD_EVAL, 32'h0004_0000, 1);
    check("busy_len", bl, TC + 1);
    check("done", s2[2], 1);
    // A sector reported as not erased is erased again before use.
    if (s2[2] !== 1'b1) begin
      wren();
      op(nes_pkg::CMD_LARGE, 32'h0004_0000, 1);
    end
    op(nes_pkg::CMD_COUNT, 32'h0004_0000, 1);
    check("busy_len", bl, TC + 1);
    check("count", cnt, 24'h000002);
    note("status");
    complete_run();
  end
endmodule : nor_erase_sequencer_test
